// ### rtl/fpe_flash_host.sv
// Host controller that drives a parallel NOR flash through its pins
// Assumes flash pins sampled synchronously to clock_in; software uses a plain register port
// Function
// RULE_01: program starts with two unlock writes and the A0H code write
// RULE_02: word loads keep output enable high; address then data are latched
// RULE_03: at most 64 words per program, all in one page
// RULE_04: unloaded page words stay erased at FFH
// RULE_05: loaded words are programmed together in one internal period
// RULE_06: each next load falls within 30 us of previous rising strobe
// RULE_07: address bits 19..6 give the page and stay valid each load
// RULE_08: address bits 5..0 pick the word; any order is accepted
// RULE_09: 100 us without a new load closes the window and programs
// RULE_10: programming ends with ready bit one; device stays reading status
// RULE_11: chip erase is six writes: unlock, 80H, unlock, 10H
// RULE_12: chip erase starts on last rising strobe, ends with ready one
// RULE_13: sector erase is six writes ending with 30H at a sector address
// RULE_14: sector address latched on falling strobe; bits 19..16 pick sector
// RULE_15: sector erase ends with ready one; device stays reading status
// RULE_16: erase suspend acts only while an erase runs
// RULE_17: suspend sets suspend bit at once, ready once really suspended
// RULE_18: while suspended only read, status, abort and resume are taken
// RULE_19: sequencer idles suspended whatever the control pins do
// RULE_20: resume clears suspend bit only if an erase was suspended
// RULE_21: after read status command every read returns the status
// RULE_22: unlock writes are 5555H/AAH then 2AAAH/55H on bits 14..0
// RULE_23: status bit seven is one for ready, zero for busy
// RULE_24: during programming only status reads are answered
// RULE_25: a mismatching write aborts the sequence back to first unlock
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/100ps
module fpe_flash_host
  import fpe_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Software register port
  input wire logic [8:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Flash pins
  output logic [19:0] flash_addr_out,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_out,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out
);
  import fpe_pkg::*;

  function automatic logic [35:0] fpe_cmd(input logic [2:0] op, input logic [6:0] step,
                                          input logic [19:0] tgt);
    logic erase;
    logic [6:0] s;
    logic [7:0] code;
    erase = (op == OP_CHIP) || (op == OP_SECT);
    s = (erase && step >= 7'h03) ? step - 7'h03 : step;
    case (op)
      OP_PROG: code = CODE_PROG;
      OP_CHIP: code = CODE_CHIP;
      OP_SECT: code = CODE_SECT;
      OP_SUSP: code = CODE_SUSP;
      OP_RESUME: code = CODE_RESUME;
      default: code = CODE_RDSTAT;
    endcase
    if (erase && step == 7'h02) begin
      code = CODE_ERASE_SETUP;
    end
    if (s == 7'h00) begin
      fpe_cmd = {5'h00, UNLOCK1_ADDR, 8'h00, UNLOCK1_DATA}; // [RULE_22]
    end else if (s == 7'h01) begin
      fpe_cmd = {5'h00, UNLOCK2_ADDR, 8'h00, UNLOCK2_DATA}; // [RULE_22]
    end else if (op == OP_SECT && step == LAST_ERASE_STEP) begin
      fpe_cmd = {tgt, 8'h00, code}; // [RULE_13] [RULE_14]
    end else begin
      fpe_cmd = {5'h00, UNLOCK1_ADDR, 8'h00, code}; // [RULE_01] [RULE_11]
    end
  endfunction

  logic [15:0] page_mem [PAGE_WORDS];
  fpe_state_e st, next_st;
  logic [2:0] op, next_op;
  logic [6:0] step, next_step;
  logic [2:0] ph, next_ph;
  logic [19:0] tgt, next_tgt;
  logic [7:0] stat, next_stat;
  logic busy, next_busy;
  logic poll, next_poll;
  logic [63:0] valid, next_valid;
  logic [31:0] next_rdata;
  logic [19:0] next_faddr;
  logic [15:0] next_fdq;
  logic next_fdq_oe, next_ce_n, next_we_n, next_oe_n;
  logic buf_wr;
  logic [35:0] w;
  logic load, adv, last;
  logic [5:0] idx;

  assign buf_wr = reg_wr_in && reg_addr_in[REG_BUF_BIT] && !busy;
  assign w = fpe_cmd(op, step, tgt);
  assign load = (op == OP_PROG) && (step >= 7'h03);
  assign idx = 6'(step - 7'h03);

  // Page buffer, any word order
  always_ff @(posedge clock_in) begin
    if (buf_wr) begin
      page_mem[reg_addr_in[7:2]] <= reg_wdata_in[15:0]; // [RULE_08]
    end
  end

  always_comb begin
    next_st = st;
    next_op = op;
    next_step = step;
    next_ph = ph;
    next_tgt = tgt;
    next_stat = stat;
    next_busy = busy;
    next_poll = poll;
    next_valid = valid;
    next_faddr = flash_addr_out;
    next_fdq = flash_dq_out;
    next_fdq_oe = flash_dq_oe_out;
    next_ce_n = flash_ce_n_out;
    next_we_n = flash_we_n_out;
    next_oe_n = flash_oe_n_out;
    next_rdata = 32'h0000_0000;
    adv = 1'b0;
    if (op == OP_PROG) begin
      last = (step == LAST_PROG_STEP);
    end else if (op == OP_CHIP || op == OP_SECT) begin
      last = (step == LAST_ERASE_STEP);
    end else begin
      last = (step == LAST_SHORT_STEP);
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        REG_STATUS: next_rdata = {22'h0, poll, busy, stat};
        REG_ADDR: next_rdata = {12'h000, tgt};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    if (buf_wr) begin
      next_valid[reg_addr_in[7:2]] = 1'b1;
    end
    case (st)
      ST_IDLE: begin
        if (reg_wr_in && reg_addr_in == REG_ADDR) begin
          next_tgt = reg_wdata_in[19:0];
        end
        if (reg_wr_in && reg_addr_in == REG_CTRL && reg_wdata_in[2:0] != 3'h0) begin
          next_op = reg_wdata_in[2:0];
          next_busy = 1'b1;
          next_step = 7'h00;
          next_ph = 3'h0;
          next_st = (reg_wdata_in[2:0] == OP_POLL) ? ST_READ : ST_WRITE;
          next_poll = (reg_wdata_in[2:0] != OP_RESUME) && (reg_wdata_in[2:0] != OP_RDSTAT);
        end
      end
      ST_WRITE: begin
        case (ph)
          3'h0: begin
            if (load && !valid[idx]) begin
              adv = 1'b1; // [RULE_04]
            end else begin
              next_faddr = load ? {tgt[19:6], idx} : w[35:16]; // [RULE_07] [RULE_08]
              next_fdq = load ? page_mem[idx] : w[15:0];
              next_fdq_oe = 1'b1;
              next_ce_n = 1'b0;
              next_oe_n = 1'b1; // [RULE_02]
              next_ph = 3'h1;
            end
          end
          3'h1: begin
            next_we_n = 1'b0;
            next_ph = 3'h2;
          end
          3'h2: begin
            next_we_n = 1'b1;
            next_ph = 3'h3;
          end
          default: begin
            next_ce_n = 1'b1;
            next_fdq_oe = 1'b0;
            next_ph = 3'h0;
            adv = 1'b1;
          end
        endcase
        if (adv) begin
          next_step = step + 7'h01; // [RULE_03] [RULE_06]
          if (last) begin
            next_valid = 64'h0; // [RULE_05] [RULE_09]
            next_ph = 3'h0;
            if (poll || op == OP_RDSTAT) begin
              next_st = ST_READ;
            end else begin
              next_st = ST_IDLE;
              next_busy = 1'b0;
            end
          end
        end
      end
      ST_READ: begin
        if (ph == 3'h0) begin
          next_ce_n = 1'b0;
          next_oe_n = 1'b0; // [RULE_21]
          next_ph = 3'h1;
        end else if (ph < 3'(READ_CYC)) begin
          next_ph = ph + 3'h1;
        end else if (ph == 3'(READ_CYC)) begin
          next_stat = flash_dq_in[7:0];
          next_ce_n = 1'b1;
          next_oe_n = 1'b1;
          next_ph = ph + 3'h1;
        end else begin
          next_ph = 3'h0;
          if (!(poll && !stat[READY_BIT])) begin // [RULE_10] [RULE_12] [RULE_15] [RULE_17] [RULE_23]
            next_st = ST_IDLE;
            next_busy = 1'b0;
            next_poll = 1'b0;
          end
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= ST_IDLE;
      op <= 3'h0;
      step <= 7'h00;
      ph <= 3'h0;
      tgt <= 20'h00000;
      stat <= 8'h00;
      busy <= 1'b0;
      poll <= 1'b0;
      valid <= 64'h0;
      reg_rdata_out <= 32'h0000_0000;
      flash_addr_out <= 20'h00000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe_out <= 1'b0;
      flash_ce_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
    end else begin
      st <= next_st;
      op <= next_op;
      step <= next_step;
      ph <= next_ph;
      tgt <= next_tgt;
      stat <= next_stat;
      busy <= next_busy;
      poll <= next_poll;
      valid <= next_valid;
      reg_rdata_out <= next_rdata;
      flash_addr_out <= next_faddr;
      flash_dq_out <= next_fdq;
      flash_dq_oe_out <= next_fdq_oe;
      flash_ce_n_out <= next_ce_n;
      flash_we_n_out <= next_we_n;
      flash_oe_n_out <= next_oe_n;
    end
  end

  // Checking helpers
  logic gap_run;
  logic [15:0] gap_cnt;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gap_run <= 1'b0;
      gap_cnt <= 16'h0000;
    end else if (st != ST_WRITE || !flash_we_n_out) begin
      gap_run <= 1'b0;
      gap_cnt <= 16'h0000;
    end else if (op == OP_PROG && load && ph == 3'h3) begin
      gap_run <= 1'b1;
      gap_cnt <= 16'h0000;
    end else if (gap_run) begin
      gap_cnt <= gap_cnt + 16'h0001;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  property p_unlock1;
    $rose(flash_we_n_out) && step == 7'h00 |->
      flash_addr_out[14:0] == UNLOCK1_ADDR && flash_dq_out[7:0] == UNLOCK1_DATA;
  endproperty
  a_unlock1: assert property (p_unlock1) else $error("first unlock wrong"); // [RULE_22]
  property p_unlock2;
    $rose(flash_we_n_out) && step == 7'h01 |->
      flash_addr_out[14:0] == UNLOCK2_ADDR && flash_dq_out[7:0] == UNLOCK2_DATA;
  endproperty
  a_unlock2: assert property (p_unlock2) else $error("second unlock wrong"); // [RULE_22]
  property p_prog_code;
    $rose(flash_we_n_out) && op == OP_PROG && step == 7'h02 |-> flash_dq_out[7:0] == CODE_PROG;
  endproperty
  a_prog_code: assert property (p_prog_code) else $error("program code wrong"); // [RULE_01]
  property p_erase_setup;
    $rose(flash_we_n_out) && (op == OP_CHIP || op == OP_SECT) && step == 7'h02
      |-> flash_dq_out[7:0] == CODE_ERASE_SETUP;
  endproperty
  a_erase_setup: assert property (p_erase_setup) else $error("erase setup wrong"); // [RULE_11]
  property p_chip_code;
    $rose(flash_we_n_out) && op == OP_CHIP && step == LAST_ERASE_STEP
      |-> flash_dq_out[7:0] == CODE_CHIP && flash_addr_out[14:0] == UNLOCK1_ADDR;
  endproperty
  a_chip_code: assert property (p_chip_code) else $error("chip erase code wrong"); // [RULE_11]
  property p_sect_code;
    $rose(flash_we_n_out) && op == OP_SECT && step == LAST_ERASE_STEP
      |-> flash_dq_out[7:0] == CODE_SECT && flash_addr_out[19:16] == tgt[19:16];
  endproperty
  a_sect_code: assert property (p_sect_code) else $error("sector erase write wrong"); // [RULE_13]
  property p_page_held;
    $fell(flash_we_n_out) && load |-> flash_addr_out[19:6] == tgt[19:6] && step <= LAST_PROG_STEP;
  endproperty
  a_page_held: assert property (p_page_held) else $error("page address moved"); // [RULE_07]
  property p_load_gap;
    gap_run |-> gap_cnt < 16'(LOAD_GAP_CYC);
  endproperty
  a_load_gap: assert property (p_load_gap) else $error("load gap too long"); // [RULE_06]
  property p_we_pulse;
    $fell(flash_we_n_out) |-> !flash_ce_n_out && flash_oe_n_out && flash_dq_oe_out
      ##1 $rose(flash_we_n_out) ##1 flash_ce_n_out;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write pulse malformed"); // [RULE_02]
  property p_poll_until_ready;
    st == ST_READ && ph == 3'(READ_CYC + 1) && poll && !stat[READY_BIT] |=> st == ST_READ;
  endproperty
  a_poll_until_ready: assert property (p_poll_until_ready) else $error("left before ready"); // [RULE_10]
endmodule

// ### rtl/fpe_pkg.sv
// Package for the flash program/erase host controller
// Assumes a 20 MHz system clock and an asynchronous parallel NOR flash
package fpe_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int LOAD_GAP_US = 30;
  localparam int LOAD_GAP_CYC = LOAD_GAP_US * (CLK_HZ / 1_000_000);
  localparam int READ_ACC_NS = 200;
  localparam int READ_CYC = (READ_ACC_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PAGE_WORDS = 64;
  // Flash command words
  localparam logic [14:0] UNLOCK1_ADDR = 15'h5555;
  localparam logic [14:0] UNLOCK2_ADDR = 15'h2AAA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CODE_PROG = 8'hA0;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP = 8'h10;
  localparam logic [7:0] CODE_SECT = 8'h30;
  localparam logic [7:0] CODE_SUSP = 8'hB0;
  localparam logic [7:0] CODE_RESUME = 8'hD0;
  localparam logic [7:0] CODE_RDSTAT = 8'h70;
  localparam int READY_BIT = 7;
  localparam int SUSP_BIT = 6;
  // Software register map
  localparam logic [8:0] REG_CTRL = 9'h000;
  localparam logic [8:0] REG_ADDR = 9'h004;
  localparam logic [8:0] REG_STATUS = 9'h008;
  localparam int REG_BUF_BIT = 8;
  // Operation codes written to REG_CTRL
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_CHIP = 3'h2;
  localparam logic [2:0] OP_SECT = 3'h3;
  localparam logic [2:0] OP_SUSP = 3'h4;
  localparam logic [2:0] OP_RESUME = 3'h5;
  localparam logic [2:0] OP_RDSTAT = 3'h6;
  localparam logic [2:0] OP_POLL = 3'h7;
  localparam logic [6:0] LAST_PROG_STEP = 7'h42;
  localparam logic [6:0] LAST_ERASE_STEP = 7'h05;
  localparam logic [6:0] LAST_SHORT_STEP = 7'h02;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b100
  } fpe_state_e;
endpackage

// ### sim/fpe_flash_model.sv
// Behavioural parallel NOR flash at the far side of the host controller
// Assumes pins sampled on clock_in; every read returns the status word
`timescale 1ns/100ps
module fpe_flash_model #(
  parameter int GAP_MAX = 600,
  parameter int LOAD_END = 2000,
  parameter int BUSY_CYC = 200
) (
  input wire logic clock_in,
  input wire logic [19:0] addr_in,
  input wire logic [15:0] dq_in,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  output logic [15:0] dq_out = '0
);
  logic [15:0] mem [int];
  logic [15:0] bw [64];
  logic [63:0] ld = '0;
  logic [19:0] la = '0;
  logic [19:0] pg = '0;
  logic we_q = 1;
  logic rdy = 1;
  logic sus = 0;
  logic lding = 0;
  logic ers = 0;
  int seq = 0, gap = 0, bsy = 0, bad = 0, progs = 0, erases = 0, sect = -1;
  function automatic logic [15:0] rd_word(input int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  function automatic logic ok(input logic [19:0] a, input logic [14:0] e, input logic [7:0] d);
    return a[14:0] == e && dq_in[7:0] == d;
  endfunction
  task automatic start_erase(input int s);
    ers = 1;
    rdy = 0;
    bsy = BUSY_CYC;
    erases++;
    sect = s;
    if (s < 0) mem.delete();
    else foreach (mem[k]) if (k[19:16] == s[3:0]) mem[k] = 16'hFFFF;
  endtask
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    if (lding) begin
      if (gap > GAP_MAX || (ld != '0 && a[19:6] != pg[19:6])) bad++;
      pg = a;
      bw[a[5:0]] = d;
      ld[a[5:0]] = 1;
      gap = 0;
    end else case (seq)
      0: seq = ok(a, 15'h5555, 8'hAA) ? 1 : 0;
      1: seq = ok(a, 15'h2AAA, 8'h55) ? 2 : 0;
      3: seq = ok(a, 15'h5555, 8'hAA) ? 4 : 0;
      4: seq = ok(a, 15'h2AAA, 8'h55) ? 5 : 0;
      5: begin
        seq = 0;
        if (ok(a, 15'h5555, 8'h10)) start_erase(-1);
        else if (d[7:0] == 8'h30) start_erase(int'(a[19:16]));
      end
      default: begin
        seq = 0;
        if (a[14:0] != 15'h5555) seq = 0;
        else if (d[7:0] == 8'h80 && rdy && !sus) seq = 3;
        else if (d[7:0] == 8'hA0 && rdy && !sus) begin
          lding = 1;
          gap = 0;
          ld = '0;
          rdy = 0;
        end else if (d[7:0] == 8'hB0 && ers && !sus) begin
          sus = 1;
          rdy = 0;
        end else if (d[7:0] == 8'hD0 && sus) begin
          sus = 0;
          rdy = 0;
        end
      end
    endcase
  endtask
  always @(posedge clock_in) begin
    we_q <= we_n_in;
    if (we_q && !we_n_in && !ce_n_in) la = addr_in;
    if (!we_q && we_n_in && !ce_n_in) begin
      if (!oe_n_in) bad++;
      wr(la, dq_in);
    end
    if (lding) gap++;
    if (lding && gap >= LOAD_END) begin
      for (int i = 0; i < 64; i++) mem[{pg[19:6], 6'(i)}] = ld[i] ? bw[i] : 16'hFFFF;
      progs++;
      lding = 0;
      bsy = BUSY_CYC;
    end
    if (sus && ers && !rdy) rdy = 1;
    else if (bsy > 0 && !sus) begin
      bsy--;
      if (bsy == 0) begin
        rdy = 1;
        ers = 0;
      end
    end
    if (!ce_n_in && !oe_n_in) dq_out <= {8'h00, rdy, sus, 6'h00};
    else dq_out <= ~dq_out;
  end
endmodule

// ### sim/test_fpe_flash_host.sv
// Testbench for the flash host controller against the flash model
// Assumes the register map and op codes of fpe_pkg
`timescale 1ns/100ps
module test_fpe_flash_host;
  import fpe_pkg::*;
  logic clock_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, chk = 0, chk_q = 0;
  logic [8:0] reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out, lfsr = 32'h5054, rv;
  logic [19:0] fa, p1, p2;
  logic [15:0] fdo, fdq, mdq, ew [64];
  logic fdoe, fce, fwe, foe;
  logic [31:0] exp_q [$], msk_q [$];
  int num_errors = 0, checks_done = 0, cyc = 0;
  assign fdq = fdoe ? fdo : mdq;
  fpe_flash_host fpe_flash_host_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .flash_addr_out(fa),
    .flash_dq_in(fdq), .flash_dq_out(fdo), .flash_dq_oe_out(fdoe),
    .flash_ce_n_out(fce), .flash_we_n_out(fwe), .flash_oe_n_out(foe));
  fpe_flash_model fpe_flash_model_inst (.clock_in(clock_in), .addr_in(fa), .dq_in(fdq),
    .ce_n_in(fce), .we_n_in(fwe), .oe_n_in(foe), .dq_out(mdq));
  initial begin
    forever #25 clock_in = ~clock_in;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] a, input logic [31:0] e, input string m);
    checks_done++;
    if (a !== e) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, a, e);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1;
    @(posedge clock_in);
    reg_wr_in <= 0;
  endtask
  task automatic rd(input logic [8:0] a, input logic c, output logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1;
    chk <= c;
    @(posedge clock_in);
    reg_rd_in <= 0;
    chk <= 0;
    #1 d = reg_rdata_out;
  endtask
  task automatic exp_rd(input logic [8:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    rd(a, 1, rv);
  endtask
  task automatic op(input logic [2:0] c);
    int n;
    n = 0;
    wr(REG_CTRL, {29'h0, c});
    rd(REG_STATUS, 0, rv);
    while (rv[8] !== 1'b0 && n < 3000) begin
      rd(REG_STATUS, 0, rv);
      n++;
    end
    cmp(32'(n < 3000), 1, "op finished");
  endtask
  task automatic prog(input logic [19:0] pa);
    for (int i = 0; i < 64; i++) begin
      lfsr = nxt(lfsr);
      ew[i] = 16'hFFFF;
      if (lfsr[0] || i == 0 || i == 63) begin
        ew[i] = lfsr[15:0];
        wr(9'h100 + 9'(4 * i), lfsr);
      end
    end
    wr(REG_ADDR, {12'h000, pa});
    op(OP_PROG);
    for (int i = 0; i < 64; i++)
      cmp(32'(fpe_flash_model_inst.rd_word(int'({pa[19:6], 6'(i)}))), 32'(ew[i]), "word");
  endtask
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    chk_q <= chk;
    if (chk_q && exp_q.size() > 0) cmp(reg_rdata_out & msk_q.pop_front(), exp_q.pop_front(), "read");
    if (cyc == 30000) begin
      num_errors++;
      test_done;
    end
  end
  initial begin
    repeat (10) @(posedge clock_in);
    sys_rst_in <= 0;
    @(posedge clock_in);
    cmp({fce, fwe, foe, fdoe}, 4'hE, "idle pins");
    exp_rd(REG_STATUS, 32'h0, 32'h200);
    lfsr = nxt(lfsr);
    p1 = {4'h3, lfsr[15:6], 6'h00};
    p2 = {4'hA, lfsr[25:16], 6'h00};
    prog(p1);
    exp_rd(REG_ADDR, {12'h000, p1}, 32'hFFFFFFFF);
    exp_rd(REG_STATUS, 32'h80, 32'hC0);
    prog(p2);
    cmp(fpe_flash_model_inst.progs, 2, "program periods");
    cmp(fpe_flash_model_inst.bad, 0, "load protocol");
    wr(REG_ADDR, {12'h000, p1});
    op(OP_SECT);
    cmp(fpe_flash_model_inst.sect, 3, "sector");
    cmp(32'(fpe_flash_model_inst.rd_word(int'(p1))), 32'hFFFF, "sector erased");
    cmp(32'(fpe_flash_model_inst.rd_word(int'(p2))), 32'(ew[0]), "other sector");
    op(OP_CHIP);
    cmp(32'(fpe_flash_model_inst.rd_word(int'(p2))), 32'hFFFF, "chip erased");
    cmp(fpe_flash_model_inst.erases, 2, "erase count");
    op(OP_SUSP);
    exp_rd(REG_STATUS, 32'h80, 32'hC0);
    op(OP_RESUME);
    exp_rd(REG_STATUS, 32'h80, 32'hC0);
    op(OP_RDSTAT);
    exp_rd(REG_STATUS, 32'h80, 32'hFF);
    exp_rd(9'h00C, 32'h0, 32'hFFFFFFFF);
    repeat (4) @(posedge clock_in);
    cmp(32'(exp_q.size()), 0, "reads seen");
    test_done;
  end
endmodule
